/* File: core/pwm_mode_edge_engine.sv */
// Edge engine for one two-output modulator channel with several modulation modes.
// Functional notes
// - Phase sync from fixed register or loop duty.
// - Multi mode: A rises edge1, falls plus duty, trim.
// - Multi mode: B rises edge3, falls plus duty, trim.
// - Multi mode ignores edge registers two and four.
// - Multi B may wrap period; A may not.
// - Adaptive sample at end or middle of on-time.
// - Resonant dead times and their average computed.
// - Resonant A fall and B rise edges from average dead.
// - Resonant B falls at loop period minus tail.
// - Triangular: only B, centred pulse, no adaptive.
// - Leading edge: A falls edge1, rises earlier.
// - Leading edge adaptive sample before edge1.
// - Leading edge B rises edge4, falls before A.
// - Fixed triggers and blanking from own registers.
// - Rectifier held off, then on-time ramps slowly.
// - Diode emulation on-time from vin, vout, duty.
// - Auto switching picks base, mid, high configs.
// - Four thresholds in rising and falling pairs.
// - Base to mid above rise, back below fall.
// - Current limit ends output_a pulse after a two-flop sync.
// - Optionally output_b matches truncated output_a width.
// - Counter counts zero to period, edges on match.
`timescale 1ns/1ps
module pwm_mode_edge_engine
    import pwm_edge_pkg::*;
(
    input  wire logic      core_clk,
    input  wire logic      rst,
    input  wire logic      clk_en,
    input  wire logic      pwm_enable,
    input  wire cnt_t      period_reg,
    input  wire cnt_t      edge_reg_1,
    input  wire cnt_t      edge_reg_2,
    input  wire cnt_t      edge_reg_3,
    input  wire cnt_t      edge_reg_4,
    input  wire cnt_t      trim_a,
    input  wire cnt_t      trim_b,
    input  wire cnt_t      sample_offset_reg,
    input  wire logic      sample_half_sel,
    input  wire cnt_t      phase_reg,
    input  wire logic      phase_from_duty,
    input  wire cnt_t      loop_duty,
    input  wire cnt_t      loop_period,
    input  wire logic [5:0] base_mode_config,
    input  wire logic [5:0] mid_mode_config,
    input  wire logic [5:0] high_mode_config,
    input  wire logic      auto_switch_en,
    input  wire duty_t     low_rise_threshold,
    input  wire duty_t     low_fall_threshold,
    input  wire duty_t     high_rise_threshold,
    input  wire duty_t     high_fall_threshold,
    input  wire cnt_t      sample_trig_1_reg,
    input  wire cnt_t      sample_trig_2_reg,
    input  wire cnt_t      blank_a_begin_reg,
    input  wire cnt_t      blank_a_end_reg,
    input  wire cnt_t      blank_b_begin_reg,
    input  wire cnt_t      blank_b_end_reg,
    input  wire logic      current_limit_pin,
    input  wire logic      sr_nominal_reached,
    input  wire cnt_t      sr_on_target,
    input  wire cnt_t      vin_value,
    input  wire cnt_t      vout_value,
    output logic           output_a,
    output logic           output_b,
    output logic           adaptive_trig,
    output logic           sample_trig_1,
    output logic           sample_trig_2,
    output logic           blank_a,
    output logic           blank_b,
    output logic           phase_sync,
    output logic           cbc_truncated,
    output logic           sr_drive,
    output cnt_t           diode_emulation_on,
    output logic [1:0]     active_level
);
    // Config fields: [1:0] mode, [2] cycle-by-cycle enable, [3] B match on truncation.
    logic period_end;
    mode_sel_if msel ();
    assign msel.enable       = auto_switch_en;
    assign msel.period_start = period_end;
    assign msel.duty         = {{(DW-CW){1'b0}}, loop_duty};
    assign msel.low_rise     = low_rise_threshold;
    assign msel.low_fall     = low_fall_threshold;
    assign msel.high_rise    = high_rise_threshold;
    assign msel.high_fall    = high_fall_threshold;

    mode_level_select u_sel (
        .core_clk (core_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .sel      (msel)
    );

    // Current limit pin is asynchronous to the core clock.
    logic cl_s1_r;
    logic cl_s2_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cl_s1_r <= 1'b0;
            cl_s2_r <= 1'b0;
        end else if (clk_en) begin
            cl_s1_r <= current_limit_pin;
            cl_s2_r <= cl_s1_r;
        end
    end

    cnt_t cnt_r;
    cnt_t cnt_nxt;
    assign period_end = (cnt_r >= period_reg);

    always_comb begin
        cnt_nxt = cnt_r + SR_RAMP_STEP;
        if (!pwm_enable || period_end) cnt_nxt = CNT_ZERO;
    end

    logic [5:0] cfg;
    always_comb begin
        case (msel.level)
            LVL_MID:  cfg = mid_mode_config;
            LVL_HIGH: cfg = high_mode_config;
            default:  cfg = base_mode_config;
        endcase
    end
    pwm_mode_e mode;
    assign mode = pwm_mode_e'(cfg[1:0]);

    // Edge arithmetic, computed continuously and latched at the period boundary.
    cnt_t half_duty;
    cnt_t dead1;
    cnt_t dead2;
    cnt_t dead_avg;
    cnt_t a_fall_res;
    cnt_t le_rise;
    logic [CW:0] dead_sum;
    assign half_duty  = loop_duty >> 1;
    assign dead1      = edge_reg_3 - edge_reg_2;
    assign dead2      = edge_reg_1 + period_reg - edge_reg_4;
    assign dead_sum   = {1'b0, dead1} + {1'b0, dead2};
    assign dead_avg   = dead_sum[CW:1];
    assign a_fall_res = edge_reg_1 + loop_duty - dead_avg;
    assign le_rise    = edge_reg_1 - loop_duty + trim_a;

    cnt_t a_on_c;
    cnt_t a_off_c;
    cnt_t b_on_c;
    cnt_t b_off_c;
    cnt_t adp_c;
    logic a_use_c;
    logic adp_use_c;
    always_comb begin
        a_use_c   = 1'b1;
        adp_use_c = 1'b1;
        a_on_c    = edge_reg_1;
        a_off_c   = edge_reg_1 + loop_duty + trim_a;
        b_on_c    = edge_reg_3;
        b_off_c   = edge_reg_3 + loop_duty + trim_b;
        adp_c     = edge_reg_1 + (sample_half_sel ? half_duty : loop_duty)
                    + sample_offset_reg;
        case (mode)
            MODE_MULTI: begin
                a_off_c = edge_reg_1 + loop_duty + trim_a;
                b_on_c  = edge_reg_3;
                b_off_c = edge_reg_3 + loop_duty + trim_b;
                if (b_off_c > period_reg) b_off_c = b_off_c - period_reg - SR_RAMP_STEP;
            end
            MODE_RESONANT: begin
                a_off_c = a_fall_res;
                b_on_c  = a_fall_res + dead1;
                b_off_c = loop_period - (period_reg - edge_reg_4);
            end
            MODE_TRIANGLE: begin
                a_use_c   = 1'b0;
                adp_use_c = 1'b0;
                b_on_c    = (period_reg >> 1) - half_duty + trim_a;
                b_off_c   = (period_reg >> 1) + half_duty + trim_b;
            end
            MODE_LEADING: begin
                a_on_c  = le_rise;
                a_off_c = edge_reg_1;
                adp_c   = edge_reg_1 - (sample_half_sel ? half_duty : loop_duty)
                          + sample_offset_reg;
                b_on_c  = edge_reg_4;
                b_off_c = le_rise - (edge_reg_2 - edge_reg_3);
            end
            default: a_use_c = 1'b0;
        endcase
    end

    cnt_t a_on_r;
    cnt_t a_off_r;
    cnt_t b_on_r;
    cnt_t b_off_r;
    cnt_t adp_r;
    cnt_t phase_r;
    logic a_use_r;
    logic adp_use_r;
    logic cbc_en_r;
    logic b_match_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            a_on_r    <= CNT_ZERO;
            a_off_r   <= CNT_ZERO;
            b_on_r    <= CNT_ZERO;
            b_off_r   <= CNT_ZERO;
            adp_r     <= CNT_ZERO;
            phase_r   <= CNT_ZERO;
            a_use_r   <= 1'b0;
            adp_use_r <= 1'b0;
            cbc_en_r  <= 1'b0;
            b_match_r <= 1'b0;
        end else if (clk_en && period_end) begin
            a_on_r    <= a_on_c;
            a_off_r   <= a_off_c;
            b_on_r    <= b_on_c;
            b_off_r   <= b_off_c;
            adp_r     <= adp_c;
            phase_r   <= phase_from_duty ? loop_duty : phase_reg;
            a_use_r   <= a_use_c;
            adp_use_r <= adp_use_c;
            cbc_en_r  <= cfg[2];
            b_match_r <= cfg[3];
        end
    end

    // Output state machine and counters, registered together.
    logic a_r, a_nxt, b_r, b_nxt, trunc_r, trunc_nxt;
    cnt_t a_width_r, a_width_nxt, b_width_r, b_width_nxt;
    logic b_match_cut;
    assign b_match_cut = b_match_r && trunc_r && (b_width_r + SR_RAMP_STEP >= a_width_r);

    always_comb begin
        a_nxt       = a_r;
        b_nxt       = b_r;
        trunc_nxt   = trunc_r;
        a_width_nxt = a_r ? a_width_r + SR_RAMP_STEP : a_width_r;
        b_width_nxt = b_r ? b_width_r + SR_RAMP_STEP : b_width_r;
        if (period_end) begin
            a_nxt     = 1'b0;
            trunc_nxt = 1'b0;
        end
        if (a_use_r && cnt_nxt == a_on_r) begin
            a_nxt       = 1'b1;
            a_width_nxt = CNT_ZERO;
        end
        if (cnt_nxt == a_off_r) a_nxt = 1'b0;
        if (a_r && cbc_en_r && cl_s2_r) begin
            a_nxt     = 1'b0;
            trunc_nxt = 1'b1;
        end
        if (cnt_nxt == b_on_r) begin
            b_nxt       = 1'b1;
            b_width_nxt = CNT_ZERO;
        end
        // A wrapped pulse whose end meets its start stays on.
        if (cnt_nxt == b_off_r && !(b_r && cnt_nxt == b_on_r)) b_nxt = 1'b0;
        if (b_r && b_match_cut) b_nxt = 1'b0;
        if (!pwm_enable) begin
            a_nxt     = 1'b0;
            b_nxt     = 1'b0;
            trunc_nxt = 1'b0;
        end
    end

    // Rectifier ramp: off until nominal, then one step every SR_RAMP_PERIODS periods.
    cnt_t sr_on_r, sr_on_nxt;
    logic [SR_DIV_W-1:0] sr_div_r, sr_div_nxt;
    cnt_t de_r, de_nxt;
    logic [2*CW-1:0] de_prod;
    assign de_prod = (vin_value > vout_value) ?
                     (loop_duty * (vin_value - vout_value)) : '0;

    always_comb begin
        sr_on_nxt  = sr_on_r;
        sr_div_nxt = sr_div_r;
        de_nxt     = de_r;
        if (!sr_nominal_reached) begin
            sr_on_nxt  = SR_RESET_ON;
            sr_div_nxt = '0;
        end else if (period_end) begin
            sr_div_nxt = sr_div_r + 1'b1;
            if (sr_div_r == SR_DIV_LAST && sr_on_r < sr_on_target) begin
                sr_on_nxt = sr_on_r + SR_RAMP_STEP;
            end
        end
        // Ideal on-time is duty times (vin - vout) / vout, computed per period.
        if (period_end) begin
            de_nxt = (vout_value == CNT_ZERO) ? CNT_ZERO
                     : CW'(de_prod / {{CW{1'b0}}, vout_value});
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r              <= CNT_ZERO;
            a_r                <= 1'b0;
            b_r                <= 1'b0;
            trunc_r            <= 1'b0;
            a_width_r          <= CNT_ZERO;
            b_width_r          <= CNT_ZERO;
            sr_on_r            <= SR_RESET_ON;
            sr_div_r           <= '0;
            de_r               <= CNT_ZERO;
            output_a           <= 1'b0;
            output_b           <= 1'b0;
            adaptive_trig      <= 1'b0;
            sample_trig_1      <= 1'b0;
            sample_trig_2      <= 1'b0;
            blank_a            <= 1'b0;
            blank_b            <= 1'b0;
            phase_sync         <= 1'b0;
            cbc_truncated      <= 1'b0;
            sr_drive           <= 1'b0;
            diode_emulation_on <= CNT_ZERO;
            active_level       <= 2'b00;
        end else if (clk_en) begin
            cnt_r              <= cnt_nxt;
            a_r                <= a_nxt;
            b_r                <= b_nxt;
            trunc_r            <= trunc_nxt;
            a_width_r          <= a_width_nxt;
            b_width_r          <= b_width_nxt;
            sr_on_r            <= sr_on_nxt;
            sr_div_r           <= sr_div_nxt;
            de_r               <= de_nxt;
            output_a           <= a_nxt;
            output_b           <= b_nxt;
            adaptive_trig      <= adp_use_r && pwm_enable && (cnt_nxt == adp_r);
            sample_trig_1      <= pwm_enable && (cnt_nxt == sample_trig_1_reg);
            sample_trig_2      <= pwm_enable && (cnt_nxt == sample_trig_2_reg);
            blank_a            <= pwm_enable && (cnt_nxt == blank_a_begin_reg ? 1'b1 :
                                  cnt_nxt == blank_a_end_reg ? 1'b0 : blank_a);
            blank_b            <= pwm_enable && (cnt_nxt == blank_b_begin_reg ? 1'b1 :
                                  cnt_nxt == blank_b_end_reg ? 1'b0 : blank_b);
            phase_sync         <= pwm_enable && (cnt_nxt == phase_r);
            cbc_truncated      <= trunc_nxt;
            sr_drive           <= b_nxt && (b_width_nxt < sr_on_r);
            diode_emulation_on <= de_r;
            active_level       <= msel.level;
        end
    end
endmodule

/* File: core/pwm_edge_pkg.sv */
// Package with widths, mode codes, reset values and timing constants for the edge engine.
package pwm_edge_pkg;
    localparam int CW = 14;
    localparam int DW = 16;
    typedef logic [CW-1:0] cnt_t;
    typedef logic [DW-1:0] duty_t;
    typedef enum logic [1:0] {
        MODE_MULTI    = 2'b00,
        MODE_RESONANT = 2'b01,
        MODE_TRIANGLE = 2'b10,
        MODE_LEADING  = 2'b11
    } pwm_mode_e;
    typedef enum logic [1:0] {
        LVL_BASE = 2'b00,
        LVL_MID  = 2'b01,
        LVL_HIGH = 2'b10
    } mode_level_e;
    localparam cnt_t CNT_ZERO       = 14'h0000;
    localparam cnt_t SR_RESET_ON    = 14'h0000;
    localparam cnt_t SR_RAMP_STEP   = 14'h0001;
    localparam int   SR_RAMP_PERIODS = 64;
    localparam int   SR_DIV_W        = 6;
    localparam logic [SR_DIV_W-1:0] SR_DIV_LAST = 6'h3F;
endpackage

/* File: core/mode_sel_if.sv */
// Interface carrying the mode-level selection between the selector and the edge engine.
`timescale 1ns/1ps
interface mode_sel_if;
    import pwm_edge_pkg::*;
    logic        enable;
    logic        period_start;
    duty_t       duty;
    duty_t       low_rise;
    duty_t       low_fall;
    duty_t       high_rise;
    duty_t       high_fall;
    mode_level_e level;
    modport selector (input enable, period_start, duty, low_rise, low_fall, high_rise,
                      high_fall, output level);
    modport engine   (output enable, period_start, duty, low_rise, low_fall, high_rise,
                      high_fall, input level);
endinterface

/* File: core/mode_level_select.sv */
// Hysteretic selector choosing among the base, mid and high mode configurations.
`timescale 1ns/1ps
module mode_level_select
    import pwm_edge_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    mode_sel_if.selector     sel
);
    mode_level_e level_r;
    mode_level_e level_nxt;

    // While enabled, levels move at most one step per period, on rising and falling threshold pairs.
    always_comb begin
        level_nxt = level_r;
        if (!sel.enable) begin
            level_nxt = LVL_BASE;
        end else if (sel.period_start) begin
            case (level_r)
                LVL_BASE: begin
                    if (sel.duty > sel.low_rise) level_nxt = LVL_MID;
                end
                LVL_MID: begin
                    if (sel.duty > sel.high_rise) level_nxt = LVL_HIGH;
                    else if (sel.duty < sel.low_fall) level_nxt = LVL_BASE;
                end
                LVL_HIGH: begin
                    if (sel.duty < sel.high_fall) level_nxt = LVL_MID;
                end
                default: level_nxt = LVL_BASE;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            level_r <= LVL_BASE;
        end else if (clk_en) begin
            level_r <= level_nxt;
        end
    end

    assign sel.level = level_r;
endmodule

/* File: verification/pwm_edge_monitor.sv */
// Concurrent checks on the ports of the modulator edge engine.
`timescale 1ns/1ps
module pwm_edge_monitor
    import pwm_edge_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       pwm_enable,
    input wire logic [5:0] base_mode_config,
    input wire logic       auto_switch_en,
    input wire cnt_t       loop_duty,
    input wire duty_t      low_rise_threshold,
    input wire duty_t      low_fall_threshold,
    input wire logic       current_limit_pin,
    input wire logic       sr_nominal_reached,
    input wire logic       output_a,
    input wire logic       output_b,
    input wire logic       adaptive_trig,
    input wire logic       sample_trig_1,
    input wire logic       cbc_truncated,
    input wire logic       sr_drive,
    input wire logic [1:0] active_level
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic limit_hit;
    assign limit_hit = current_limit_pin && base_mode_config[2] && !auto_switch_en;

    AST_RESET_LOW: assert property (disable iff (1'b0) rst |-> !output_a && !output_b)
        else $error("gate output high during reset");
    AST_DISABLED_LOW: assert property (!pwm_enable [*2] |-> !output_a && !output_b)
        else $error("gate output high while disabled");
    AST_TRIG_SINGLE: assert property (sample_trig_1 |=> !sample_trig_1 [*8])
        else $error("fixed trigger longer than one cycle");
    AST_ADAPT_SINGLE: assert property (adaptive_trig |=> !adaptive_trig)
        else $error("adaptive trigger longer than one cycle");
    AST_LIMIT_CUT: assert property (limit_hit |-> ##3 !output_a)
        else $error("pulse not cut after current limit");
    AST_LIMIT_FLAG: assert property (limit_hit && output_a |-> ##[1:4] cbc_truncated)
        else $error("truncation flag missing");
    AST_LEVEL_STEP: assert property ($changed(active_level) |->
        active_level == $past(active_level) + 2'd1 || $past(active_level) == active_level + 2'd1)
        else $error("mode level jumped more than one step");
    AST_LEVEL_CODE: assert property (active_level != 2'b11)
        else $error("illegal mode level");
    AST_MID_UP: assert property (active_level == LVL_MID && $past(active_level) == LVL_BASE |->
        {2'b00, loop_duty} > low_rise_threshold)
        else $error("moved up without crossing rising threshold");
    AST_MID_DOWN: assert property (active_level == LVL_BASE && $past(active_level) == LVL_MID |->
        {2'b00, loop_duty} < low_fall_threshold)
        else $error("moved down without crossing falling threshold");
    AST_SR_HELD: assert property (!sr_nominal_reached [*3] |-> !sr_drive)
        else $error("rectifier driven before nominal voltage");
endmodule

bind pwm_mode_edge_engine pwm_edge_monitor i_mon (
    .core_clk(core_clk), .rst(rst), .pwm_enable(pwm_enable),
    .base_mode_config(base_mode_config), .auto_switch_en(auto_switch_en),
    .loop_duty(loop_duty), .low_rise_threshold(low_rise_threshold),
    .low_fall_threshold(low_fall_threshold), .current_limit_pin(current_limit_pin),
    .sr_nominal_reached(sr_nominal_reached), .output_a(output_a), .output_b(output_b),
    .adaptive_trig(adaptive_trig), .sample_trig_1(sample_trig_1),
    .cbc_truncated(cbc_truncated), .sr_drive(sr_drive), .active_level(active_level)
);

/* File: verification/gate_driver_model.sv */
// Behavioural gate driver pair that times the pulses it is given.
`timescale 1ns/1ps
module gate_driver_model (
    input  wire logic core_clk,
    input  wire logic gate_a,
    input  wire logic gate_b,
    output int        a_width,
    output int        b_width,
    output int        a_fall_to_b_rise,
    output int        b_fall_to_a_rise,
    output int        a_rise_cnt
);
    int   t, ar, af, br, bf;
    logic a_q = 1'b0;
    logic b_q = 1'b0;
    always @(posedge core_clk) begin
        t <= t + 1;
        a_q <= gate_a;
        b_q <= gate_b;
        if (gate_a && !a_q) begin
            ar <= t;
            a_rise_cnt <= a_rise_cnt + 1;
            b_fall_to_a_rise <= t - bf;
        end
        if (!gate_a && a_q) begin
            af <= t;
            a_width <= t - ar;
        end
        if (gate_b && !b_q) begin
            br <= t;
            a_fall_to_b_rise <= t - af;
        end
        if (!gate_b && b_q) begin
            bf <= t;
            b_width <= t - br;
        end
    end
endmodule

/* File: verification/pwm_mode_edge_engine_tb_top.sv */
// Directed testbench for the modulator edge engine.
`timescale 1ns/1ps
module pwm_mode_edge_engine_tb_top
    import pwm_edge_pkg::*;
();
    logic core_clk, rst, clk_en, pwm_enable, sample_half_sel, phase_from_duty;
    logic auto_switch_en, current_limit_pin, sr_nominal_reached;
    cnt_t period_reg, edge_reg_1, edge_reg_2, edge_reg_3, edge_reg_4, trim_a, trim_b;
    cnt_t sample_offset_reg, phase_reg, loop_duty, loop_period, sample_trig_1_reg;
    cnt_t sample_trig_2_reg, blank_a_begin_reg, blank_a_end_reg, blank_b_begin_reg;
    cnt_t blank_b_end_reg, sr_on_target, vin_value, vout_value, diode_emulation_on;
    logic [5:0] base_mode_config, mid_mode_config, high_mode_config;
    duty_t low_rise_threshold, low_fall_threshold, high_rise_threshold, high_fall_threshold;
    logic output_a, output_b, adaptive_trig, sample_trig_1, sample_trig_2, blank_a, blank_b;
    logic phase_sync, cbc_truncated, sr_drive, a_q, bl_q;
    logic [1:0] active_level;
    int a_width, b_width, a_fall_to_b_rise, b_fall_to_a_rise, a_rise_cnt, n, k;
    int n_errors, total_checks, t, t_st1, t_st2, t_ph, t_ad, t_ar, t_bl_on, t_bl_off, t_sr;

    pwm_mode_edge_engine i_dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .pwm_enable(pwm_enable), .period_reg(period_reg), .edge_reg_1(edge_reg_1),
        .edge_reg_2(edge_reg_2), .edge_reg_3(edge_reg_3), .edge_reg_4(edge_reg_4),
        .trim_a(trim_a), .trim_b(trim_b), .sample_offset_reg(sample_offset_reg),
        .sample_half_sel(sample_half_sel), .phase_reg(phase_reg),
        .phase_from_duty(phase_from_duty), .loop_duty(loop_duty), .loop_period(loop_period),
        .base_mode_config(base_mode_config), .mid_mode_config(mid_mode_config),
        .high_mode_config(high_mode_config), .auto_switch_en(auto_switch_en),
        .low_rise_threshold(low_rise_threshold), .low_fall_threshold(low_fall_threshold),
        .high_rise_threshold(high_rise_threshold), .high_fall_threshold(high_fall_threshold),
        .sample_trig_1_reg(sample_trig_1_reg), .sample_trig_2_reg(sample_trig_2_reg),
        .blank_a_begin_reg(blank_a_begin_reg), .blank_a_end_reg(blank_a_end_reg),
        .blank_b_begin_reg(blank_b_begin_reg), .blank_b_end_reg(blank_b_end_reg),
        .current_limit_pin(current_limit_pin), .sr_nominal_reached(sr_nominal_reached),
        .sr_on_target(sr_on_target), .vin_value(vin_value), .vout_value(vout_value),
        .output_a(output_a), .output_b(output_b), .adaptive_trig(adaptive_trig),
        .sample_trig_1(sample_trig_1), .sample_trig_2(sample_trig_2), .blank_a(blank_a),
        .blank_b(blank_b), .phase_sync(phase_sync), .cbc_truncated(cbc_truncated),
        .sr_drive(sr_drive), .diode_emulation_on(diode_emulation_on),
        .active_level(active_level));

    gate_driver_model i_gate (.core_clk(core_clk), .gate_a(output_a), .gate_b(output_b),
        .a_width(a_width), .b_width(b_width), .a_fall_to_b_rise(a_fall_to_b_rise),
        .b_fall_to_a_rise(b_fall_to_a_rise), .a_rise_cnt(a_rise_cnt));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Time stamps of the pulses; also cuts a hung run short.
    always @(posedge core_clk) begin
        t <= t + 1;
        a_q <= output_a;
        bl_q <= blank_a;
        if (sample_trig_1) t_st1 <= t;
        if (sample_trig_2) t_st2 <= t;
        if (phase_sync) t_ph <= t;
        if (adaptive_trig) t_ad <= t;
        if (output_a && !a_q) t_ar <= t;
        if (blank_a && !bl_q) t_bl_on <= t;
        if (!blank_a && bl_q) t_bl_off <= t;
        if (sr_drive && t_sr == 0) t_sr <= t;
        if (t == 20000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int cycles);
        repeat (cycles) @(posedge core_clk);
        #1;
    endtask

    // Loads one operating point and lets four whole periods of 101 cycles pass.
    task automatic mode(input logic [5:0] cfg, input cnt_t e1, e2, e3, e4, d, ta, tb_);
        base_mode_config = cfg;
        {edge_reg_1, edge_reg_2, edge_reg_3, edge_reg_4} = {e1, e2, e3, e4};
        {loop_duty, trim_a, trim_b} = {d, ta, tb_};
        loop_period = d << 1;
        step(404);
    endtask

    task automatic await_trig2();
        for (k = 0; k < 300 && sample_trig_2 !== 1'b1; k++) step(1);
        step(1);
    endtask

    task automatic test_done();
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        {clk_en, pwm_enable, sample_half_sel, phase_from_duty} = 4'h8;
        {auto_switch_en, current_limit_pin, sr_nominal_reached} = 3'h0;
        {base_mode_config, mid_mode_config, high_mode_config} = 18'h0_0000;
        {period_reg, phase_reg, sample_offset_reg} = {14'h0064, 14'h002D, 14'h0004};
        {sample_trig_1_reg, sample_trig_2_reg} = {14'h0014, 14'h003C};
        {blank_a_begin_reg, blank_a_end_reg} = {14'h000A, 14'h0019};
        {blank_b_begin_reg, blank_b_end_reg, sr_on_target} = {14'h0030, 14'h0040, 14'h0010};
        {vin_value, vout_value} = {14'h012C, 14'h0064};
        {low_rise_threshold, low_fall_threshold} = {16'h0064, 16'h0032};
        {high_rise_threshold, high_fall_threshold} = {16'h0FA0, 16'h0BB8};
        {edge_reg_1, edge_reg_2, edge_reg_3, edge_reg_4, trim_a, trim_b} = '0;
        {loop_duty, loop_period} = '0;
        step(8);
        rst = 1'b0;
        step(4);
        pwm_enable = 1'b1;
        mode(6'h00, 14'h000A, 14'h0007, 14'h0032, 14'h0003, 14'h001E, 14'h0002, 14'h0005);
        check(a_width, 32);
        check(b_width, 35);
        check(a_fall_to_b_rise, 8);
        check(diode_emulation_on, 60);
        await_trig2();
        check(t_st2 - t_st1, 40);
        check(t_bl_off - t_bl_on, 15);
        check(t_ph - t_st1, 25);
        check(t_ad - t_ar, 34);
        {sample_half_sel, phase_from_duty} = 2'h3;
        step(404);
        await_trig2();
        check(t_ph - t_st1, 10);
        check(t_ad - t_ar, 19);
        mode(6'h00, 14'h000A, 14'h3FFF, 14'h005A, 14'h1234, 14'h001E, 14'h0002, 14'h0005);
        check(a_width, 32);
        check(b_width, 35);
        check(a_fall_to_b_rise, 48);
        mode(6'h01, 14'h0005, 14'h002D, 14'h0032, 14'h005F, 14'h0028, 14'h0000, 14'h0000);
        check(a_width, 33);
        check(a_fall_to_b_rise, 5);
        check(b_width, 32);
        mode(6'h02, 14'h0005, 14'h002D, 14'h0032, 14'h005F, 14'h0028, 14'h0002, 14'h0003);
        n = a_rise_cnt;
        k = t_ad;
        check(b_width, 41);
        step(202);
        check(a_rise_cnt, n);
        check(t_ad, k);
        mode(6'h03, 14'h0050, 14'h0014, 14'h000F, 14'h0005, 14'h001E, 14'h0002, 14'h0000);
        check(a_width, 28);
        check(b_width, 42);
        check(b_fall_to_a_rise, 5);
        mode(6'h0C, 14'h000A, 14'h0007, 14'h0032, 14'h0003, 14'h001E, 14'h0002, 14'h0005);
        for (k = 0; k < 200 && output_a !== 1'b1; k++) step(1);
        step(5);
        current_limit_pin = 1'b1;
        step(1);
        current_limit_pin = 1'b0;
        step(3);
        check(output_a, 1'b0);
        check(cbc_truncated, 1'b1);
        step(60);
        check(b_width, a_width);
        base_mode_config = 6'h00;
        auto_switch_en = 1'b1;
        loop_duty = 14'h0078;
        step(404);
        check(active_level, LVL_MID);
        loop_duty = 14'h0050;
        step(404);
        check(active_level, LVL_MID);
        loop_duty = 14'h0028;
        step(404);
        check(active_level, LVL_BASE);
        loop_duty = 14'h1000;
        step(808);
        check(active_level, LVL_HIGH);
        check(sr_drive, 1'b0);
        sr_nominal_reached = 1'b1;
        loop_duty = 14'h001E;
        n = t;
        step(6666);
        check((t_sr - n) inside {[6400:6530]}, 1'b1);
        pwm_enable = 1'b0;
        step(2);
        check({output_a, output_b}, 2'b00);
        test_done();
    end
endmodule
